// [bench/pmc_power_mode_controller_sva.sv]
// Checker of the power mode controller's port behaviour.
// Assumes it is bound to the top module and sees only its ports.
module pmc_power_mode_controller_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Bus response
    input wire logic hreadyout,
    input wire logic hresp,
    // Wake request
    input wire logic anyIrq,
    // Power control
    input wire logic [pmc_pkg::NSUB-1:0] subEnable,
    input wire logic [pmc_pkg::NSUB-1:0] subClkGate,
    input wire logic lowSpeedClkEn,
    input wire logic mainClkEn,
    input wire pmc_pkg::pmc_reg_s regCtl,
    input wire logic [1:0] modeOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // --------------------
    // Sequences
    // --------------------
    // Mode seen twice, so the outputs one cycle behind have caught up
    sequence s_sleep;
        modeOut == 2'h2 && $past(modeOut) == 2'h2;
    endsequence
    sequence s_hib;
        modeOut == 2'h3 && $past(modeOut) == 2'h3;
    endsequence
    sequence s_altIrq;
        (modeOut == 2'h1 && anyIrq) [*3];
    endsequence
    sequence s_buzz;
        ##[2:70] (!regCtl.digOn && !regCtl.anaOn) ##[1:70] (regCtl.digOn && regCtl.anaOn);
    endsequence

    // --------------------
    // Properties
    // --------------------
    property p_bus_okay; hreadyout && !hresp; endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus answer not ready or not okay");
    property p_clk_gate; subClkGate == ~subEnable; endproperty
    a_clk_gate: assert property (p_clk_gate)
        else $error("clock gate differs from enable");
    property p_sleep_off; s_sleep |-> subEnable == '0; endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("subsystem enabled in sleep");
    property p_sleep_lowclk; s_sleep |-> lowSpeedClkEn; endproperty
    a_sleep_lowclk: assert property (p_sleep_lowclk)
        else $error("low speed clock stopped in sleep");
    property p_sleep_buzz; $rose(modeOut == 2'h2) |-> s_buzz; endproperty
    a_sleep_buzz: assert property (p_sleep_buzz)
        else $error("regulators not pulsed in sleep");
    property p_hib_clk; s_hib |-> !mainClkEn && !lowSpeedClkEn; endproperty
    a_hib_clk: assert property (p_hib_clk)
        else $error("clock running in hibernate");
    property p_hib_reg; s_hib |-> regCtl == 3'b001 && subEnable == '0; endproperty
    a_hib_reg: assert property (p_hib_reg)
        else $error("wrong regulators in hibernate");
    property p_wake_path;
        modeOut[1] |=> modeOut == $past(modeOut) || modeOut == 2'h0;
    endproperty
    a_wake_path: assert property (p_wake_path)
        else $error("low power mode left other than to active");
    property p_wake_core; $fell(modeOut[1]) |-> ##[1:2] subEnable[pmc_pkg::CPU_BIT]; endproperty
    a_wake_core: assert property (p_wake_core)
        else $error("core not enabled after wake");
    property p_alt_wake; s_altIrq |-> ##[1:4] modeOut == 2'h0; endproperty
    a_alt_wake: assert property (p_alt_wake)
        else $error("interrupt did not end alternate active");
endmodule

bind pmc_power_mode_controller pmc_power_mode_controller_sva u_sva (
    .ref_clk(ref_clk), .reset_n(reset_n), .hreadyout(hreadyout), .hresp(hresp),
    .anyIrq(anyIrq), .subEnable(subEnable), .subClkGate(subClkGate),
    .lowSpeedClkEn(lowSpeedClkEn), .mainClkEn(mainClkEn), .regCtl(regCtl),
    .modeOut(modeOut)
);

// [bench/pmc_power_mode_controller_tb_top.sv]
// Self-checking bench of the power mode controller.
// Assumes the bound checker; bus and wake pins change just after rising edges.
module pmc_power_mode_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic wr;
        logic [7:0] a;
        logic [31:0] d;
    } pmc_row_s;

    // --------------------
    // Ordinary cases: reset values, write and read back, unmapped place
    // --------------------
    localparam pmc_row_s ROWS [18] = '{
        {1'b0, pmc_pkg::MODE_OFF, 32'h0}, {1'b0, pmc_pkg::ACT_TPL_OFF, 32'hff},
        {1'b0, pmc_pkg::ALT_TPL_OFF, 32'h2}, {1'b0, pmc_pkg::WAKE_EN_OFF, 32'h3f},
        {1'b0, pmc_pkg::MASK_OFF, 32'h0}, {1'b0, pmc_pkg::REG_CFG_OFF, 32'h0},
        {1'b0, pmc_pkg::STATUS_OFF, 32'h0}, {1'b0, pmc_pkg::STATE_OFF, 32'heff},
        {1'b1, pmc_pkg::ACT_TPL_OFF, 32'h5a},
        {1'b0, pmc_pkg::ACT_TPL_OFF, 32'h5a}, {1'b1, pmc_pkg::ALT_TPL_OFF, 32'h3e},
        {1'b0, pmc_pkg::ALT_TPL_OFF, 32'h3e}, {1'b1, pmc_pkg::REG_CFG_OFF, 32'h3},
        {1'b0, pmc_pkg::REG_CFG_OFF, 32'h3}, {1'b1, 8'h20, 32'hffffffff},
        {1'b0, 8'h20, 32'h0}, {1'b1, pmc_pkg::MASK_OFF, 32'h1},
        {1'b0, pmc_pkg::MASK_OFF, 32'h1}
    };
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [5:0] wakeSrc = 6'h0;
    logic anyIrq = 1'b0;
    logic hreadyout, hresp, lowSpeedClkEn, mainClkEn, irq;
    logic [31:0] hrdata;
    logic [7:0] subEnable, subClkGate;
    logic [1:0] modeOut;
    pmc_pkg::pmc_reg_s regCtl;
    int errCount = 0;
    int checkCount = 0;
    int cycles = 0;

    pmc_power_mode_controller DUT (
        .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .wakeSrc(wakeSrc), .anyIrq(anyIrq), .subEnable(subEnable),
        .subClkGate(subClkGate), .lowSpeedClkEn(lowSpeedClkEn), .mainClkEn(mainClkEn),
        .regCtl(regCtl), .modeOut(modeOut), .irq(irq)
    );

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Whole run is near 8000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            $display("unexpected at %0t: run too long", $time);
            finishTest();
        end
    end

    // --------------------
    // Tasks
    // --------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errCount++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Ready and read data taken at the rising edge, before the design's updates land
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        logic s;
        @(posedge ref_clk);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do begin
            @(posedge ref_clk);
            s = hreadyout;
        end while (s !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge ref_clk);
            s = hreadyout;
            rd = hrdata;
        end while (s !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(x, e);
    endtask
    // Mode register first, outputs one cycle later
    task automatic setMode(input logic [1:0] m);
        wr(pmc_pkg::MODE_OFF, 32'(m));
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic waitMode(input logic [1:0] m, input int lim);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (modeOut !== m && n <= lim) begin
            @(negedge ref_clk);
            n++;
        end
        check(32'(n <= lim), 32'h1);
    endtask
    task automatic finishTest;
        $display("checks %0d mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // --------------------
    // Sequence of tests
    // --------------------
    initial begin
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        hsel <= 1'b1;
        @(negedge ref_clk);
        check(32'(modeOut), 32'h0);
        check(32'(subEnable), 32'hff);
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) begin
                wr(ROWS[i].a, ROWS[i].d);
            end else begin
                rdc(ROWS[i].a, ROWS[i].d);
            end
        end
        @(negedge ref_clk);
        // Core still forced on since reset, until active is written
        check(32'(subEnable), 32'h5b);
        check(32'(subClkGate), 32'ha4);
        check(32'(regCtl), 32'h1);
        wr(pmc_pkg::REG_CFG_OFF, 32'h0);
        setMode(2'h1);
        check(32'(modeOut), 32'h1);
        check(32'(subEnable), 32'h3e);
        @(posedge ref_clk);
        anyIrq <= 1'b1;
        waitMode(2'h0, 5);
        @(posedge ref_clk);
        anyIrq <= 1'b0;
        repeat (2) @(negedge ref_clk);
        check(32'(subEnable), 32'h5b);
        check(32'(irq), 32'h1);
        rdc(pmc_pkg::STATUS_OFF, 32'h1);
        rdc(pmc_pkg::STATUS_OFF, 32'h0);
        setMode(2'h0);
        check(32'(irq), 32'h0);
        check(32'(subEnable), 32'h5a);
        // Every sleep wake source, odd ones entered from alternate active
        for (int i = 0; i < pmc_pkg::NWAKE; i++) begin
            if (i % 2 == 1) begin
                setMode(2'h1);
            end
            setMode(2'h2);
            check(32'(subEnable), 32'h0);
            check(32'({mainClkEn, lowSpeedClkEn}), 32'h1);
            if (i == 0) begin
                wr(pmc_pkg::WAKE_EN_OFF, 32'h3e);
                @(posedge ref_clk);
                anyIrq <= 1'b1;
                wakeSrc <= 6'h1;
                wr(pmc_pkg::MODE_OFF, 32'h0);
                repeat (20) @(negedge ref_clk);
                check(32'(modeOut), 32'h2);
                check(32'(irq), 32'h0);
                @(posedge ref_clk);
                anyIrq <= 1'b0;
                wakeSrc <= 6'h0;
                wr(pmc_pkg::WAKE_EN_OFF, 32'h3f);
                rdc(pmc_pkg::STATUS_OFF, 32'h2);
            end
            @(posedge ref_clk);
            wakeSrc <= 6'(1 << i);
            // Under 15 us: active seen within 600 cycles of the pin
            waitMode(2'h0, 599);
            @(posedge ref_clk);
            wakeSrc <= 6'h0;
            repeat (2) @(negedge ref_clk);
            check(32'(subEnable[0]), 32'h1);
            check(32'(irq), 32'h1);
            rdc(pmc_pkg::STATUS_OFF, 32'h1);
            setMode(2'h0);
        end
        setMode(2'h3);
        check(32'(regCtl), 32'h1);
        check(32'({mainClkEn, lowSpeedClkEn}), 32'h0);
        @(posedge ref_clk);
        wakeSrc <= 6'h3d;
        repeat (100) @(negedge ref_clk);
        check(32'(modeOut), 32'h3);
        @(posedge ref_clk);
        wakeSrc <= 6'h2;
        waitMode(2'h0, 3999);
        @(posedge ref_clk);
        wakeSrc <= 6'h0;
        repeat (2) @(negedge ref_clk);
        check(32'({mainClkEn, subEnable[0]}), 32'h3);
        setMode(2'h2);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        check(32'(modeOut), 32'h0);
        rdc(pmc_pkg::ACT_TPL_OFF, 32'hff);
        finishTest();
    end
endmodule

// [logic/pmc_buzz.sv]
// Regulator pulse generator: periodic on-window enable for buzzed mode.
// Assumes ref_clk domain; run is a same-domain level.
module pmc_buzz (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Control
    input wire logic run,
    output logic pulseOn
);
    logic [6:0] cnt_q, cnt_d;

    always_comb begin
        if (!run || cnt_q == 7'(pmc_pkg::BUZZ_PERIOD - 1)) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + 7'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign pulseOn = run && (cnt_q < 7'(pmc_pkg::BUZZ_ON));
endmodule

// [logic/pmc_pkg.sv]
// Package for the power mode controller: register map, fields, timing.
// Assumes a 40 MHz ref_clk and an AHB-Lite slave with 32-bit data.
package pmc_pkg;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PMC_ACTIVE,
        PMC_ALT_ACTIVE,
        PMC_SLEEP,
        PMC_HIBERNATE
    } pmc_mode_e;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_OFF = 8'h00;
    localparam logic [7:0] ACT_TPL_OFF = 8'h04;
    localparam logic [7:0] ALT_TPL_OFF = 8'h08;
    localparam logic [7:0] REG_CFG_OFF = 8'h0c;
    localparam logic [7:0] WAKE_EN_OFF = 8'h10;
    localparam logic [7:0] STATUS_OFF = 8'h14;
    localparam logic [7:0] MASK_OFF = 8'h18;
    localparam logic [7:0] STATE_OFF = 8'h1c;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int NSUB = 8;
    localparam int CPU_BIT = 0;
    localparam int PDB_BIT = 1;
    localparam int NWAKE = 6;
    // Wake sources: comparator, pin unit, i2c match, rtc, timewheel, lvd
    localparam int WK_CMP = 0;
    localparam int WK_PIN = 1;
    localparam int WK_I2C = 2;
    localparam int WK_RTC = 3;
    localparam int WK_TW = 4;
    localparam int WK_LVD = 5;
    localparam int REG_EXT_DIG = 0;
    localparam int REG_EXT_ANA = 1;
    // Status bits
    localparam int ST_WAKE = 0;
    localparam int ST_BADREQ = 1;
    localparam int NSTAT = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [NSUB-1:0] ACT_TPL_RST = 8'hff;
    localparam logic [NSUB-1:0] ALT_TPL_RST = 8'h02;
    localparam logic [NWAKE-1:0] WAKE_EN_RST = 6'h3f;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int SLEEP_WAKE_NS = 15000;
    localparam int HIB_WAKE_NS = 100000;
    localparam int CNT_W = 13;
    // Two sync stages, the waking flag and the last step sit on top of the count
    localparam int WAKE_LAT = 4;
    localparam logic [CNT_W-1:0] SLEEP_WAKE_CYC =
        CNT_W'((SLEEP_WAKE_NS * CLK_MHZ) / 1000 - WAKE_LAT - 1);
    localparam logic [CNT_W-1:0] HIB_WAKE_CYC =
        CNT_W'((HIB_WAKE_NS * CLK_MHZ) / 1000 - WAKE_LAT - 1);
    localparam int BUZZ_PERIOD = 64;
    localparam int BUZZ_ON = 8;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic digOn;
        logic anaOn;
        logic hibOn;
    } pmc_reg_s;

endpackage

// [logic/pmc_power_mode_controller.sv]
// Power mode controller: four global modes, subsystem gating, regulators, wake.
// Assumes AHB-Lite master on ref_clk; wake and pin lines are async pins.
//
// Local design decisions: register access over AHB-Lite and the address map.
module pmc_power_mode_controller (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Wake sources and interrupt requests (async)
    input wire logic [pmc_pkg::NWAKE-1:0] wakeSrc,
    input wire logic anyIrq,
    // Subsystem and clock control
    output logic [pmc_pkg::NSUB-1:0] subEnable,
    output logic [pmc_pkg::NSUB-1:0] subClkGate,
    output logic lowSpeedClkEn,
    output logic mainClkEn,
    output pmc_pkg::pmc_reg_s regCtl,
    output logic [1:0] modeOut,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [pmc_pkg::NWAKE:0] syncA_q, syncB_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= {anyIrq, wakeSrc};
            syncB_q <= syncA_q;
        end
    end
    logic [pmc_pkg::NWAKE-1:0] wakeS;
    logic irqS;
    assign wakeS = syncB_q[pmc_pkg::NWAKE-1:0];
    assign irqS = syncB_q[pmc_pkg::NWAKE];

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic wrPend_q, wrPend_d, rdPend_q, rdPend_d;
    logic [7:0] addr_q, addr_d;
    logic take;
    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        wrPend_d = take && hwrite;
        rdPend_d = take && !hwrite;
        addr_d = take ? haddr[7:0] : addr_q;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q <= '0;
        end else begin
            wrPend_q <= wrPend_d;
            rdPend_q <= rdPend_d;
            addr_q <= addr_d;
        end
    end

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [pmc_pkg::NSUB-1:0] actTpl_q, actTpl_d, altTpl_q, altTpl_d;
    logic [1:0] extReg_q, extReg_d;
    logic [pmc_pkg::NWAKE-1:0] wakeEn_q, wakeEn_d;
    logic [pmc_pkg::NSTAT-1:0] mask_q, mask_d;
    logic cpuForce_q, cpuForce_d;

    always_comb begin
        actTpl_d = actTpl_q;
        altTpl_d = altTpl_q;
        extReg_d = extReg_q;
        wakeEn_d = wakeEn_q;
        mask_d = mask_q;
        if (wrPend_q) begin
            if (hit(addr_q, pmc_pkg::ACT_TPL_OFF)) actTpl_d = hwdata[pmc_pkg::NSUB-1:0];
            if (hit(addr_q, pmc_pkg::ALT_TPL_OFF)) altTpl_d = hwdata[pmc_pkg::NSUB-1:0];
            if (hit(addr_q, pmc_pkg::REG_CFG_OFF)) extReg_d = hwdata[1:0];
            if (hit(addr_q, pmc_pkg::WAKE_EN_OFF)) wakeEn_d = hwdata[pmc_pkg::NWAKE-1:0];
            if (hit(addr_q, pmc_pkg::MASK_OFF)) mask_d = hwdata[pmc_pkg::NSTAT-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            actTpl_q <= pmc_pkg::ACT_TPL_RST;
            altTpl_q <= pmc_pkg::ALT_TPL_RST;
            extReg_q <= '0;
            wakeEn_q <= pmc_pkg::WAKE_EN_RST;
            mask_q <= '0;
        end else begin
            actTpl_q <= actTpl_d;
            altTpl_q <= altTpl_d;
            extReg_q <= extReg_d;
            wakeEn_q <= wakeEn_d;
            mask_q <= mask_d;
        end
    end

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    pmc_pkg::pmc_mode_e mode_q, mode_d;
    logic waking_q, waking_d;
    logic [pmc_pkg::CNT_W-1:0] wcnt_q, wcnt_d;
    logic wakeEv, badReq, modeWr;
    logic [1:0] reqMode;
    logic [pmc_pkg::NWAKE-1:0] sleepWk;

    assign modeWr = wrPend_q && hit(addr_q, pmc_pkg::MODE_OFF);
    assign reqMode = hwdata[1:0];
    assign sleepWk = wakeS & wakeEn_q;

    always_comb begin
        mode_d = mode_q;
        waking_d = waking_q;
        wcnt_d = wcnt_q;
        wakeEv = 1'b0;
        badReq = 1'b0;
        cpuForce_d = cpuForce_q;
        unique case (mode_q)
            pmc_pkg::PMC_ACTIVE, pmc_pkg::PMC_ALT_ACTIVE: begin
                // Any interrupt returns alternate active to active
                if (mode_q == pmc_pkg::PMC_ALT_ACTIVE && irqS) begin
                    mode_d = pmc_pkg::PMC_ACTIVE;
                    cpuForce_d = 1'b1;
                    wakeEv = 1'b1;
                end else if (modeWr) begin
                    // Entry only from either active mode by write
                    mode_d = pmc_pkg::pmc_mode_e'(reqMode);
                    waking_d = 1'b0;
                    wcnt_d = '0;
                    if (reqMode == 2'(pmc_pkg::PMC_ACTIVE)) cpuForce_d = 1'b0;
                end
            end
            pmc_pkg::PMC_SLEEP: begin
                if (modeWr) badReq = 1'b1;
                if (!waking_q && (|sleepWk)) begin
                    waking_d = 1'b1;
                end
                if (waking_q) begin
                    // Settle time so regulators are stable on return
                    if (wcnt_q == pmc_pkg::SLEEP_WAKE_CYC) begin
                        mode_d = pmc_pkg::PMC_ACTIVE;
                        cpuForce_d = 1'b1;
                        waking_d = 1'b0;
                        wakeEv = 1'b1;
                    end else begin
                        wcnt_d = wcnt_q + 1'b1;
                    end
                end
            end
            pmc_pkg::PMC_HIBERNATE: begin
                if (modeWr) badReq = 1'b1;
                // Pin unit is the only way out
                if (!waking_q && wakeS[pmc_pkg::WK_PIN] && wakeEn_q[pmc_pkg::WK_PIN]) begin
                    waking_d = 1'b1;
                end
                if (waking_q) begin
                    if (wcnt_q == pmc_pkg::HIB_WAKE_CYC) begin
                        mode_d = pmc_pkg::PMC_ACTIVE;
                        cpuForce_d = 1'b1;
                        waking_d = 1'b0;
                        wakeEv = 1'b1;
                    end else begin
                        wcnt_d = wcnt_q + 1'b1;
                    end
                end
            end
        endcase
        // Active-mode interrupt also re-enables a self-disabled core
        if (mode_q == pmc_pkg::PMC_ACTIVE && irqS) cpuForce_d = 1'b1;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= pmc_pkg::PMC_ACTIVE;
            waking_q <= 1'b0;
            wcnt_q <= '0;
            cpuForce_q <= 1'b1;
        end else begin
            mode_q <= mode_d;
            waking_q <= waking_d;
            wcnt_q <= wcnt_d;
            cpuForce_q <= cpuForce_d;
        end
    end

    // ------------------------------------------------------------
    // Status and interrupt
    // ------------------------------------------------------------
    logic [pmc_pkg::NSTAT-1:0] stat_q, stat_d, statSet;
    assign statSet = {badReq, wakeEv};
    always_comb begin
        stat_d = stat_q;
        if (rdPend_q && hit(addr_q, pmc_pkg::STATUS_OFF)) stat_d = '0;
        // Set wins over the read-clear
        stat_d = stat_d | statSet;
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_d;
        end
    end
    assign irq = |(stat_q & mask_q);

    // ------------------------------------------------------------
    // Subsystem gating and regulators
    // ------------------------------------------------------------
    logic buzzRun, buzzOn;
    assign buzzRun = (mode_q == pmc_pkg::PMC_SLEEP);

    pmc_buzz u_buzz (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .run(buzzRun),
        .pulseOn(buzzOn)
    );

    logic [pmc_pkg::NSUB-1:0] en_d, en_q;
    pmc_pkg::pmc_reg_s reg_d, reg_q;
    logic lsClk_d, lsClk_q, mainClk_d, mainClk_q;

    always_comb begin
        en_d = '0;
        reg_d = '{digOn: 1'b0, anaOn: 1'b0, hibOn: 1'b1};
        lsClk_d = 1'b1;
        mainClk_d = 1'b1;
        unique case (mode_q)
            pmc_pkg::PMC_ACTIVE: begin
                en_d = actTpl_q;
                if (cpuForce_q) en_d[pmc_pkg::CPU_BIT] = 1'b1;
                reg_d = '{digOn: !extReg_q[0], anaOn: !extReg_q[1], hibOn: 1'b1};
            end
            pmc_pkg::PMC_ALT_ACTIVE: begin
                // Core may be off while digital blocks keep running
                en_d = altTpl_q;
                reg_d = '{digOn: !extReg_q[0], anaOn: !extReg_q[1], hibOn: 1'b1};
            end
            pmc_pkg::PMC_SLEEP: begin
                en_d = '0;
                mainClk_d = 1'b0;
                lsClk_d = 1'b1;
                // Pulsed regulators, unless externally regulated
                reg_d = '{digOn: buzzOn && !extReg_q[0], anaOn: buzzOn && !extReg_q[1],
                          hibOn: 1'b1};
            end
            pmc_pkg::PMC_HIBERNATE: begin
                en_d = '0;
                mainClk_d = 1'b0;
                lsClk_d = 1'b0;
                reg_d = '{digOn: 1'b0, anaOn: 1'b0, hibOn: 1'b1};
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            en_q <= pmc_pkg::ACT_TPL_RST;
            reg_q <= '{digOn: 1'b1, anaOn: 1'b1, hibOn: 1'b1};
            lsClk_q <= 1'b1;
            mainClk_q <= 1'b1;
        end else begin
            en_q <= en_d;
            reg_q <= reg_d;
            lsClk_q <= lsClk_d;
            mainClk_q <= mainClk_d;
        end
    end

    assign subEnable = en_q;
    assign subClkGate = ~en_q;
    assign regCtl = reg_q;
    assign lowSpeedClkEn = lsClk_q;
    assign mainClkEn = mainClk_q;
    assign modeOut = mode_q;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rd;
    always_comb begin
        rd = '0;
        if (rdPend_q) begin
            unique case (addr_q)
                pmc_pkg::MODE_OFF: rd[1:0] = mode_q;
                pmc_pkg::ACT_TPL_OFF: rd[pmc_pkg::NSUB-1:0] = actTpl_q;
                pmc_pkg::ALT_TPL_OFF: rd[pmc_pkg::NSUB-1:0] = altTpl_q;
                pmc_pkg::REG_CFG_OFF: rd[1:0] = extReg_q;
                pmc_pkg::WAKE_EN_OFF: rd[pmc_pkg::NWAKE-1:0] = wakeEn_q;
                pmc_pkg::STATUS_OFF: rd[pmc_pkg::NSTAT-1:0] = stat_q;
                pmc_pkg::MASK_OFF: rd[pmc_pkg::NSTAT-1:0] = mask_q;
                pmc_pkg::STATE_OFF: rd[11:0] = {reg_q, waking_q, en_q};
                default: rd = '0;
            endcase
        end
    end
    // Combinational from registered address; unmapped reads return zero
    assign hrdata = rd;
endmodule
